// [rtl/iep_regs.v]
// interrupt enable / priority register bank with request resolver
// assumes core special-function register port, single-cycle writes and reads,
// peripherals present level pending flags synchronous to sys_clk
//
// What this block does
// [R1] Basic priority bits 7 and 6 always read one, writes ignored.
// [R2] Basic priority bits 5..0 set level of timer2, serial0, timer1, ext1, timer0, ext0.
// [R3] Extended mask one bits 7..4 enable comparator rise/fall sources.
// [R4] Extended mask one bits 3..0 enable counter array, conv0 window, mgmt bus, periph.
// [R5] Extended mask two bits 6,4..0 enable serial1, conv2, timer4, conv0 done, timer3.
// [R6] Bits 7 and 5 of mask two and level two read zero, ignore writes.
// [R7] Extended level one bits 7..4 set comparator rise/fall priority.
// [R8] Extended level one bits 3..0 set counter array, conv0 window, bus, periph priority.
// [R9] Extended level two bits 6,4..0 set serial1, conv2, timer4, conv0 done, timer3 priority.
// [R10] All five registers decode at fixed addresses regardless of register page.
// [R11] Low routine may be preempted by high; high routine never preempted.
// [R12] Same-cycle requests: higher level wins, ties by fixed source order.
// [R13] Global gate clear blocks every source; set lets each follow its mask.
// [R14] Request counts only if pending, enabled and gate set; winner shown each cycle.
// [R15] Register writes take effect next edge, arbitration uses them next cycle.
`timescale 1ns/1ps
`include "iep_consts.vh"

module iep_regs #(
	parameter NSRC = 20
) (
	// clock and reset
	input  wire            sys_clk,
	input  wire            resetn,
	// special-function register port
	input  wire [7:0]      sfr_addr,
	input  wire [7:0]      sfr_wdata,
	input  wire            sfr_wr,
	input  wire            sfr_rd,
	output reg  [7:0]      sfr_rdata,
	// global gate and basic enables, kept by the core's enable register
	input  wire            global_interrupt_gate,
	input  wire [5:0]      basic_mask,
	// pending flags in fixed order: ext0,t0,ext1,t1,serial0,t2,periph,bus,
	// conv0win,carray,c0f,c0r,c1f,c1r,t3,conv0done,t4,conv2win,conv2done,serial1
	input  wire [19:0]     pending,
	// service state from the core
	input  wire            isr_enter,
	input  wire            isr_return,
	// request to the core
	output reg             irq_valid,
	output reg             irq_high,
	output reg  [4:0]      irq_source
);
	reg  [5:0]  basic_prio_r;
	reg  [7:0]  ext_mask1_r;
	reg  [7:0]  ext_mask2_r;
	reg  [7:0]  ext_level1_r;
	reg  [7:0]  ext_level2_r;
	reg         in_low_r;
	reg         in_high_r;
	reg  [7:0]  rdata_nxt;
	wire [19:0] enable_vec;
	wire [19:0] level_vec;
	wire [19:0] req_vec;
	wire        win_valid;
	wire        win_high;
	wire [4:0]  win_id;
	wire        allowed;

	// register writes, one address each, no page qualifier [R10] [R15]
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			basic_prio_r <= 6'h00;
			ext_mask1_r <= `IEP_RST_EXT;
			ext_mask2_r <= `IEP_RST_EXT;
			ext_level1_r <= `IEP_RST_EXT;
			ext_level2_r <= `IEP_RST_EXT;
		end
		else if (sfr_wr)
		begin
			case (sfr_addr)
				`IEP_ADDR_BASIC_PRIO: basic_prio_r <= sfr_wdata[5:0]; // [R1] [R2]
				`IEP_ADDR_EXT_MASK1:  ext_mask1_r <= sfr_wdata; // [R3] [R4]
				`IEP_ADDR_EXT_MASK2:  ext_mask2_r <= sfr_wdata & `IEP_EXT2_BITS; // [R5] [R6]
				`IEP_ADDR_EXT_LEVEL1: ext_level1_r <= sfr_wdata; // [R7] [R8]
				`IEP_ADDR_EXT_LEVEL2: ext_level2_r <= sfr_wdata & `IEP_EXT2_BITS; // [R9] [R6]
				default: ;
			endcase
		end
	end

	// read mux, unused bits forced per register
	// unmapped addresses read zero, so no other register of the space sees an echo
	always @*
	begin
		case (sfr_addr)
			`IEP_ADDR_BASIC_PRIO: rdata_nxt = `IEP_BASIC_PRIO_ONES | {2'b00, basic_prio_r}; // [R1]
			`IEP_ADDR_EXT_MASK1:  rdata_nxt = ext_mask1_r;
			`IEP_ADDR_EXT_MASK2:  rdata_nxt = ext_mask2_r & `IEP_EXT2_BITS; // [R6]
			`IEP_ADDR_EXT_LEVEL1: rdata_nxt = ext_level1_r;
			`IEP_ADDR_EXT_LEVEL2: rdata_nxt = ext_level2_r & `IEP_EXT2_BITS; // [R6]
			default:              rdata_nxt = 8'h00;
		endcase
	end

	// read data registered, zero when not reading
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			sfr_rdata <= 8'h00;
		else
			sfr_rdata <= sfr_rd ? rdata_nxt : 8'h00;
	end

	// named enable fields of extended mask one [R3] [R4]
	wire        comp1_rise_mask     = ext_mask1_r[7];
	wire        comp1_fall_mask     = ext_mask1_r[6];
	wire        comp0_rise_mask     = ext_mask1_r[5];
	wire        comp0_fall_mask     = ext_mask1_r[4];
	wire        counter_array_mask  = ext_mask1_r[3];
	wire        conv0_window_mask   = ext_mask1_r[2];
	wire        mgmt_bus_mask       = ext_mask1_r[1];
	wire        serial_periph_mask  = ext_mask1_r[0];
	// named enable fields of extended mask two, bits 7 and 5 stay zero [R5]
	wire        serial1_mask        = ext_mask2_r[6];
	wire        conv2_done_mask     = ext_mask2_r[4];
	wire        conv2_window_mask   = ext_mask2_r[3];
	wire        timer4_mask         = ext_mask2_r[2];
	wire        conv0_done_mask     = ext_mask2_r[1];
	wire        timer3_mask         = ext_mask2_r[0];

	// named level fields of the basic priority register [R2]
	wire        timer2_level        = basic_prio_r[5];
	wire        serial0_level       = basic_prio_r[4];
	wire        timer1_level        = basic_prio_r[3];
	wire        ext_input1_level    = basic_prio_r[2];
	wire        timer0_level        = basic_prio_r[1];
	wire        ext_input0_level    = basic_prio_r[0];
	// named level fields of extended level one [R7] [R8]
	wire        comp1_rise_level    = ext_level1_r[7];
	wire        comp1_fall_level    = ext_level1_r[6];
	wire        comp0_rise_level    = ext_level1_r[5];
	wire        comp0_fall_level    = ext_level1_r[4];
	wire        counter_array_level = ext_level1_r[3];
	wire        conv0_window_level  = ext_level1_r[2];
	wire        mgmt_bus_level      = ext_level1_r[1];
	wire        serial_periph_level = ext_level1_r[0];
	// named level fields of extended level two, bits 7 and 5 stay zero [R9]
	wire        serial1_level       = ext_level2_r[6];
	wire        conv2_done_level    = ext_level2_r[4];
	wire        conv2_window_level  = ext_level2_r[3];
	wire        timer4_level        = ext_level2_r[2];
	wire        conv0_done_level    = ext_level2_r[1];
	wire        timer3_level        = ext_level2_r[0];

	// per-source enable in fixed arbitration order, bit 0 first [R3] [R4] [R5] [R12]
	// comparators run fall-before-rise, zero before one, so a swapped field
	// here silently changes which source wins a tie
	assign enable_vec = {
		serial1_mask, conv2_done_mask, conv2_window_mask, timer4_mask,
		conv0_done_mask, timer3_mask,
		comp1_rise_mask, comp1_fall_mask, comp0_rise_mask, comp0_fall_mask,
		counter_array_mask, conv0_window_mask, mgmt_bus_mask, serial_periph_mask,
		basic_mask};

	// per-source level in the same order as the enables [R2] [R7] [R8] [R9]
	assign level_vec = {
		serial1_level, conv2_done_level, conv2_window_level, timer4_level,
		conv0_done_level, timer3_level,
		comp1_rise_level, comp1_fall_level, comp0_rise_level, comp0_fall_level,
		counter_array_level, conv0_window_level, mgmt_bus_level, serial_periph_level,
		timer2_level, serial0_level, timer1_level, ext_input1_level, timer0_level,
		ext_input0_level};

	// gate, mask and pending all needed [R13] [R14]
	assign req_vec = pending & enable_vec & {20{global_interrupt_gate}};

	iep_resolver #(
		.NSRC (NSRC),
		.IW   (5)
	) u_resolver (
		.req       (req_vec),
		.level     (level_vec),
		.win_valid (win_valid),
		.win_high  (win_high),
		.win_id    (win_id)
	);

	// track service level; high never preempted, low only by high [R11]
	assign allowed = !in_high_r && (!in_low_r || win_high);

	// a high entry leaves the low flag set, so a suspended low routine
	// stays marked and blocks other low requests until it returns too

	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			in_low_r <= 1'b0;
			in_high_r <= 1'b0;
		end
		else if (isr_enter && irq_valid)
		begin
			if (irq_high)
				in_high_r <= 1'b1;
			else
				in_low_r <= 1'b1;
		end
		else if (isr_return)
		begin
			// returning from the innermost routine
			if (in_high_r)
				in_high_r <= 1'b0;
			else
				in_low_r <= 1'b0;
		end
	end

	// winner presented each cycle [R14] [R12]
	// valid may stand one cycle past an entry, the core must not enter twice
	// level and source follow the resolver even while valid is held low
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_valid <= 1'b0;
			irq_high <= 1'b0;
			irq_source <= 5'h00;
		end
		else
		begin
			irq_valid <= win_valid & allowed; // [R11]
			irq_high <= win_high;
			irq_source <= win_id;
		end
	end
endmodule

// [rtl/iep_consts.vh]
// interrupt enable / priority register bank: addresses, reset values, field positions
// assumes an 8-bit special-function register address space shared by all pages
`ifndef IEP_CONSTS_VH
`define IEP_CONSTS_VH

// register addresses, identical on every register page
`define IEP_ADDR_BASIC_PRIO  8'hb8
`define IEP_ADDR_EXT_MASK1   8'he6
`define IEP_ADDR_EXT_MASK2   8'he7
`define IEP_ADDR_EXT_LEVEL1  8'hf6
`define IEP_ADDR_EXT_LEVEL2  8'hf7

// reset values
`define IEP_RST_BASIC_PRIO   8'hc0
`define IEP_RST_EXT          8'h00

// implemented bit masks
`define IEP_BASIC_PRIO_BITS  8'h3f
`define IEP_BASIC_PRIO_ONES  8'hc0
`define IEP_EXT2_BITS        8'h5f

// source count and source index order (fixed tie-break order, 0 wins)
`define IEP_NSRC             20
`define IEP_SRC_W            5
`define IEP_NONE             5'h1f

`endif

// [rtl/iep_resolver.v]
// priority resolver: picks the highest-level, lowest-index request
// assumes requests already gated by pending, enable and global gate
`timescale 1ns/1ps

module iep_resolver #(
	parameter NSRC = 26,
	parameter IW   = 5
) (
	// request and level vectors, bit 0 is highest fixed order
	input  wire [NSRC-1:0] req,
	input  wire [NSRC-1:0] level,
	// winner
	output reg             win_valid,
	output reg             win_high,
	output reg  [IW-1:0]   win_id
);
	integer i;
	reg     found_hi;
	reg     found_lo;
	reg     [IW-1:0] id_hi;
	reg     [IW-1:0] id_lo;

	// scan from the last source down so the lowest index is kept
	always @*
	begin
		found_hi = 1'b0;
		found_lo = 1'b0;
		id_hi = {IW{1'b0}};
		id_lo = {IW{1'b0}};
		for (i = NSRC - 1; i >= 0; i = i - 1)
		begin
			if (req[i] && level[i])
			begin
				found_hi = 1'b1;
				id_hi = i[IW-1:0];
			end
			if (req[i] && !level[i])
			begin
				found_lo = 1'b1;
				id_lo = i[IW-1:0];
			end
		end
		// high level beats low, ties by fixed order [R12]
		win_valid = found_hi | found_lo;
		win_high = found_hi;
		win_id = found_hi ? id_hi : id_lo;
	end
endmodule

// [dv/iep_regs_assertions.sv]
// checker for the register port and request output
// sees only the ports of iep_regs, bound below
`timescale 1ns/1ps
module iep_regs_chk #(parameter NSRC = 20) (
	// clock and reset
	input wire		sys_clk,
	input wire		resetn,
	// register port
	input wire [7:0]	sfr_addr,
	input wire [7:0]	sfr_wdata,
	input wire		sfr_wr,
	input wire		sfr_rd,
	input wire [7:0]	sfr_rdata,
	// sources and core
	input wire		global_interrupt_gate,
	input wire [5:0]	basic_mask,
	input wire [19:0]	pending,
	input wire		isr_enter,
	input wire		isr_return,
	input wire		irq_valid,
	input wire		irq_high,
	input wire [4:0]	irq_source
);
	reg [19:0]	pend_r;
	// flags as the block saw them at the last edge
	always @(posedge sys_clk or negedge resetn)
		if (!resetn)
			pend_r <= 20'h00000;
		else
			pend_r <= pending;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_rdata_idle: assert property (!sfr_rd |=> sfr_rdata == 8'h00) else $error("rdata not idle");
	a_basic_ones: assert property (
		sfr_rd && sfr_addr == 8'hb8 |=> sfr_rdata[7:6] == 2'b11) else $error("top bits");
	a_two_unused: assert property (
		sfr_rd && (sfr_addr == 8'he7 || sfr_addr == 8'hf7) |=> !sfr_rdata[7] && !sfr_rdata[5])
		else $error("unused bits");
	a_unmapped_zero: assert property (
		sfr_rd && sfr_addr == 8'h90 |=> sfr_rdata == 8'h00) else $error("unmapped read");
	a_gate_blocks: assert property (
		!global_interrupt_gate |=> !irq_valid) else $error("gate ignored");
	a_idle_no_req: assert property (pending == 20'h00000 |=> !irq_valid) else $error("spurious");
	a_source_range: assert property (irq_valid |-> irq_source < 5'd20) else $error("bad source");
	a_source_pend: assert property (irq_valid |-> pend_r[irq_source]) else $error("not pending");
endmodule
bind iep_regs iep_regs_chk #(.NSRC(NSRC)) u_chk (.*);

// [dv/iep_core_model.sv]
// core-side model: vectors on command while a request shows, returns on command
// assumes commands change at the falling edge
`timescale 1ns/1ps
module iep_core_model (
	// clock, request and commands
	input wire	sys_clk,
	input wire	irq_valid,
	input wire	do_take,
	input wire	do_ret,
	// to the block
	output wire	isr_enter,
	output wire	isr_return
);
	// enter only alongside a shown request
	assign isr_enter = do_take & irq_valid;
	assign isr_return = do_ret;
endmodule

// [dv/test_iep_regs.sv]
// self-checking bench for the enable and priority register bank
// assumes the core model and the bound checker
`timescale 1ns/1ps
module test_iep_regs;
	reg		sys_clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	reg		global_interrupt_gate = 1'b0, do_take = 1'b0, do_ret = 1'b0;
	reg [7:0]	sfr_addr = 8'h00, sfr_wdata = 8'h00;
	reg [5:0]	basic_mask = 6'h00;
	reg [19:0]	pending = 20'h00000;
	reg [39:0]	ev, am = 40'hb8e6e7f6f7;
	wire		isr_enter, isr_return, irq_valid, irq_high;
	wire [7:0]	sfr_rdata;
	wire [4:0]	irq_source;
	integer		err_total = 0, tests_run = 0, cyc = 0, i;
	iep_regs dut (.sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.global_interrupt_gate(global_interrupt_gate), .basic_mask(basic_mask),
		.pending(pending), .isr_enter(isr_enter), .isr_return(isr_return),
		.irq_valid(irq_valid), .irq_high(irq_high), .irq_source(irq_source));
	iep_core_model core (.sys_clk(sys_clk), .irq_valid(irq_valid), .do_take(do_take),
		.do_ret(do_ret), .isr_enter(isr_enter), .isr_return(isr_return));
	task chk(input [7:0] seen, input [7:0] exp);
	begin
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(negedge sys_clk) {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
		@(negedge sys_clk) sfr_wr = 1'b0;
	end
	endtask
	task rd(input [7:0] a, input [7:0] e);
	begin
		@(negedge sys_clk) {sfr_rd, sfr_addr} = {1'b1, a};
		@(negedge sys_clk) sfr_rd = 1'b0;
		chk(sfr_rdata, e);
	end
	endtask
	// e is valid, level, source; level and source ignored when invalid
	task irq(input [6:0] e);
	begin
		repeat (2) @(negedge sys_clk);
		chk({1'b0, irq_valid, irq_valid ? {irq_high, irq_source} : 6'h00}, {1'b0, e});
	end
	endtask
	task pulse(input t);
	begin
		{do_take, do_ret} = {t, !t};
		@(negedge sys_clk) {do_take, do_ret} = 2'b00;
	end
	endtask
	task wrap_up;
	begin
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	initial forever #2 sys_clk = ~sys_clk;
	// hang guard
	always @(posedge sys_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 2000)
		begin
			err_total = err_total + 1;
			wrap_up;
		end
	end
	initial
	begin
		repeat (10) @(negedge sys_clk);
		resetn = 1'b1;
		// reset values, all ones written, all zeros written
		for (i = 0; i < 15; i = i + 1)
		begin
			if (i > 4)
				wr(am[i % 5 * 8 +: 8], i < 10 ? 8'hff : 8'h00);
			ev = (i > 4 && i < 10) ? 40'hffff5fff5f : 40'hc000000000;
			rd(am[i % 5 * 8 +: 8], ev[i % 5 * 8 +: 8]);
		end
		wr(8'h90, 8'hff);
		rd(8'h90, 8'h00);
		{global_interrupt_gate, basic_mask, pending} = {1'b1, 6'h3f, 20'h00003};
		irq(7'h40);
		wr(8'hb8, 8'h02);
		irq(7'h61);
		global_interrupt_gate = 1'b0;
		irq(7'h00);
		{global_interrupt_gate, pending} = {1'b1, 20'h80200};
		irq(7'h00);
		wr(8'he7, 8'h40);
		irq(7'h53);
		wr(8'hf7, 8'h40);
		wr(8'he6, 8'h08);
		irq(7'h73);
		wr(8'hf6, 8'h08);
		irq(7'h69);
		pending = 20'h00001;
		irq(7'h40);
		pulse(1'b1);
		irq(7'h00);
		pending = 20'h00003;
		irq(7'h61);
		pulse(1'b1);
		irq(7'h00);
		pending = 20'h00001;
		pulse(1'b0);
		irq(7'h00);
		pulse(1'b0);
		irq(7'h40);
		// comparator order: comp0 fall is source 10, comp1 rise source 13
		{pending, basic_mask} = {20'h02400, 6'h00};
		wr(8'he6, 8'h10);
		irq(7'h4a);
		wr(8'he6, 8'h90);
		wr(8'hf6, 8'h80);
		irq(7'h6d);
		wrap_up;
	end
endmodule
